// ==== dv/llpf_top_tb.sv ====
// Purpose: Self-checking bench for the light-load phase and fault manager
// Assumes: Short timer parameters; straps settle before reset release
// Notes:   Comparator levels take a few clocks through the synchroniser
`timescale 1ns/1ns
module llpf_top_tb;
  localparam int LK = 40;
  localparam int HC = 50;
  localparam int PG = 16;
  logic               clk = 1'b0;
  logic               rst_n = 1'b0;
  logic               cyc = 1'b0;
  logic               stb = 1'b0;
  logic               we = 1'b0;
  logic [7:0]         adr = 8'h00;
  logic [31:0]        wdat = 32'h0000_0000;
  logic [31:0]        rdat;
  logic [31:0]        rd;
  logic               ack;
  llpf_pkg::llpf_in_t ci = '0;
  logic               sw_en, p1, p2, cut, ldo, pg;
  logic [3:0]         scl;
  logic [1:0]         soff, skp;
  int                 fail_count = 0;
  int                 checks_done = 0;

  // Core clock, 50 ns period
  always #25 clk = ~clk;

  llpf_top #(.LOCK_CYC(LK), .HICCUP_CYC(HC), .POWER_GOOD_FLAG_CYC(PG)) i_dut (
    .clk(clk), .rst_n(rst_n), .wb_cyc_i(cyc), .wb_stb_i(stb), .wb_we_i(we),
    .wb_adr_i(adr), .wb_sel_i(4'h1), .wb_dat_i(wdat), .wb_dat_o(rdat), .wb_ack_o(ack),
    .cmp_in(ci), .switch_en(sw_en), .phase1_en(p1), .phase2_en(p2),
    .ph2_duty_scale(scl), .sr_cutoff_en(cut), .sr_off(soff), .pulse_skip(skp),
    .ldo_en(ldo), .power_good_flag(pg));

  task automatic clkn(input int n);
    repeat (n) @(posedge clk);
  endtask : clkn

  task automatic chk(input string nm, input logic [7:0] e, input logic [7:0] g);
    checks_done++;
    if (g !== e) begin
      fail_count++;
      $display("MISMATCH %s expected %h seen %h", nm, e, g);
    end
  endtask : chk

  task automatic stop_test();
    $display("Checks %0d, mismatches %0d", checks_done, fail_count);
    if (fail_count == 0 && checks_done > 0) $display("No errors found");
    else $display("Errors were found");
    $finish;
  endtask : stop_test

  // One classic Wishbone cycle, bounded wait for ack
  task automatic wb(input logic w, input logic [7:0] a, input logic [31:0] d);
    int n;
    n = 0;
    cyc <= 1'b1;
    stb <= 1'b1;
    we <= w;
    adr <= a;
    wdat <= d;
    do begin
      @(posedge clk);
      n++;
    end while (ack !== 1'b1 && n < 20);
    rd = rdat;
    cyc <= 1'b0;
    stb <= 1'b0;
    if (n >= 20) begin
      fail_count++;
      stop_test();
    end
    @(posedge clk);
  endtask : wb

  // Reset with straps set, enable, soft-start, then run
  task automatic boot(input logic h, input logic l, input logic r);
    llpf_pkg::llpf_in_t v;
    v = '0;
    v.strap_hi = h;
    v.strap_lo = l;
    v.resp_strap = r;
    v.en_pin = 1'b1;
    rst_n <= 1'b0;
    ci <= v;
    clkn(16);
    rst_n <= 1'b1;
    clkn(6);
    wb(1'b1, llpf_pkg::ADR_CTRL, 32'h0000_0001);
    clkn(6);
    chk("cutoff_soft", 8'h01, 8'(cut));
    ci.ss_done <= 1'b1;
    clkn(6);
    chk("power_good_flag_early", 8'h00, 8'(pg));
    clkn(PG + 4);
    chk("power_good_flag_late", 8'h01, 8'(pg));
  endtask : boot

  task automatic t_mode(input logic h, input logic l, input logic [7:0] m);
    boot(h, l, 1'b1);
    ci.zero_cross <= 2'h1;
    ci.skip_req <= 2'h2;
    clkn(6);
    wb(1'b0, llpf_pkg::ADR_STATUS, 32'h0000_0000);
    chk("mode", m, 8'(rd[11:10]));
    chk("resp_hiccup", 8'h01, 8'(rd[0]));
    chk("cutoff", 8'(m != 8'h00), 8'(cut));
    chk("sr_off", m != 8'h00 ? 8'h01 : 8'h00, 8'(soff));
    chk("skip", m != 8'h00 ? 8'h02 : 8'h00, 8'(skp));
  endtask : t_mode

  task automatic pulse();
    ci.sw_cycle <= 1'b1;
    clkn(3);
    ci.sw_cycle <= 1'b0;
    clkn(5);
  endtask : pulse

  task automatic t_shed();
    ci.ext_sync <= 1'b1;
    ci.averaged_input_current_level_below_drop <= 1'b1;
    repeat (3) pulse();
    chk("sync_keep", 8'h09, 8'(scl));
    ci.ext_sync <= 1'b0;
    clkn(LK + 8);
    for (int k = 1; k <= 9; k++) begin
      pulse();
      chk("ramp", 8'(9 - k), 8'(scl));
    end
    chk("ph2_shed", 8'h00, 8'(p2));
    ci.peak_limit <= 2'h2;
    clkn(5);
    chk("add_peak", 8'h01, 8'(p2));
    ci.peak_limit <= 2'h0;
    clkn(LK / 2);
    pulse();
    chk("lockout", 8'h09, 8'(scl));
    clkn(LK);
    pulse();
    chk("relock", 8'h08, 8'(scl));
    ci.averaged_input_current_level_above_add <= 1'b1;
    clkn(5);
    chk("add_averaged_input_current_level", 8'h19, {3'h0, p2, scl});
  endtask : t_shed

  task automatic t_fault(input int i, input logic r);
    boot(1'b0, 1'b1, r);
    ci.fault <= llpf_pkg::llpf_fault_t'(6'h20 >> i);
    clkn(6);
    chk("stop", 8'h00, 8'(sw_en));
    chk("ph1_stop", 8'h00, 8'(p1));
    chk("ldo", 8'h01, 8'(ldo));
    wb(1'b0, llpf_pkg::ADR_FAULT, 32'h0000_0000);
    chk("sticky", 8'(6'h20 >> i), 8'(rd[5:0]));
    ci.fault <= llpf_pkg::FAULT_NONE;
    clkn(HC + 10);
    chk("restart", 8'(r), 8'(sw_en));
    ci.en_pin <= 1'b0;
    clkn(6);
    ci.en_pin <= 1'b1;
    clkn(8);
    chk("rearm", 8'h01, 8'(sw_en));
  endtask : t_fault

  // Main sequence
  initial begin
    t_mode(1'b1, 1'b0, 8'h01);
    t_mode(1'b0, 1'b1, 8'h00);
    t_mode(1'b0, 1'b0, 8'h02);
    t_shed();
    wb(1'b0, 8'h0C, 32'h0000_0000);
    chk("unmapped", 8'h00, rd[7:0]);
    for (int i = 0; i < 6; i++) t_fault(i, 1'b1);
    t_fault(2, 1'b0);
    stop_test();
  end
endmodule : llpf_top_tb

// ==== src/llpf_pkg.sv ====
// Purpose: Shared constants, enumerations and carriers of the light-load phase and fault manager
// Assumes: 20 MHz core clock, comparator and strap decisions arrive as one-bit levels
// Notes:   Long counts are derived here and overridable as top-level parameters
package llpf_pkg;

  // Core clock and timing figures in their own units
  localparam int unsigned CLK_HZ      = 20_000_000;
  localparam int unsigned LOCKOUT_US  = 1500;
  localparam int unsigned HICCUP_MS   = 500;
  localparam int unsigned POWER_GOOD_FLAG_US    = 500;
  localparam int unsigned LOCKOUT_CYC = LOCKOUT_US * (CLK_HZ / 1_000_000);
  localparam int unsigned HICCUP_CYC  = HICCUP_MS * (CLK_HZ / 1_000);
  localparam int unsigned POWER_GOOD_FLAG_CYC   = POWER_GOOD_FLAG_US * (CLK_HZ / 1_000_000);
  localparam int          TMR_W       = 24;

  // Duty ramp of the second phase, in switching cycles
  localparam logic [3:0]  RAMP_STEPS  = 4'h9;
  localparam logic [3:0]  RAMP_ZERO   = 4'h0;
  localparam logic [3:0]  RAMP_ONE    = 4'h1;

  // Strap settle wait after reset release
  localparam logic [1:0]  STRAP_WAIT  = 2'h3;
  localparam logic [1:0]  STRAP_STEP  = 2'h1;

  // Wishbone register map (byte addresses)
  localparam int          ADR_W       = 8;
  localparam logic [7:0]  ADR_CTRL    = 8'h00;
  localparam logic [7:0]  ADR_STATUS  = 8'h04;
  localparam logic [7:0]  ADR_FAULT   = 8'h08;
  localparam int          CTRL_EN_BIT = 0;
  localparam logic        CTRL_EN_RST = 1'b0;
  localparam logic [31:0] DATA_ZERO   = 32'h0000_0000;

  typedef enum logic [1:0] {
    MODE_CCM     = 2'b00,
    MODE_DE      = 2'b01,
    MODE_DE_SHED = 2'b10
  } llpf_mode_t;

  typedef enum logic [2:0] {
    ST_OFF    = 3'b000,
    ST_SOFT   = 3'b001,
    ST_RUN    = 3'b010,
    ST_HICCUP = 3'b011,
    ST_LATCH  = 3'b100
  } llpf_state_t;

  typedef enum logic [1:0] {
    PH_BOTH   = 2'b00,
    PH_RAMP   = 2'b01,
    PH_SINGLE = 2'b10
  } llpf_phase_t;

  // Fault comparator decisions
  typedef struct packed {
    logic in_ov;
    logic avg_oc;
    logic peak_oc;
    logic out_ov;
    logic loop_short;
    logic freq_loss;
  } llpf_fault_t;

  localparam llpf_fault_t FAULT_NONE = 6'h00;
  localparam int          FAULT_PAD  = 32 - $bits(llpf_fault_t);

  // All asynchronous inputs, gathered for one synchroniser bank
  typedef struct packed {
    logic        en_pin;
    logic        strap_hi;
    logic        strap_lo;
    logic        resp_strap;
    logic        averaged_input_current_level_below_drop;
    logic        averaged_input_current_level_above_add;
    logic [1:0]  peak_limit;
    llpf_fault_t fault;
    logic        ss_done;
    logic        sw_cycle;
    logic        ext_sync;
    logic [1:0]  zero_cross;
    logic [1:0]  skip_req;
  } llpf_in_t;

  localparam int IN_W = $bits(llpf_in_t);

  // Status word as read by software
  typedef struct packed {
    llpf_mode_t  mode;
    logic        de_active;
    logic        shed_en;
    logic        ph2_on;
    llpf_state_t state;
    llpf_phase_t phase;
    logic        power_good;
    logic        hiccup_sel;
  } llpf_status_t;

  localparam int STAT_PAD = 32 - $bits(llpf_status_t);

endpackage : llpf_pkg

// ==== src/llpf_sync.sv ====
// Purpose: Two-flop synchroniser bank for comparator and strap levels
// Assumes: Each bit is an independent level
// Notes:   The first stage feeds only the second stage
`timescale 1ns/1ns
module llpf_sync #(
  parameter int W = 1
) (
  // Clock and reset
  input  wire logic         clk,
  input  wire logic         rst_n,
  // Levels
  input  wire logic [W-1:0] d,
  output logic      [W-1:0] q
);

  logic [W-1:0] meta_r;

  // Two stages per bit
  genvar i;
  generate
    for (i = 0; i < W; i++) begin : g_bit
      always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
          meta_r[i] <= 1'b0;
          q[i]      <= 1'b0;
        end else begin
          meta_r[i] <= d[i];
          q[i]      <= meta_r[i];
        end
      end
    end
  endgenerate

endmodule : llpf_sync

// ==== src/llpf_timer.sv ====
// Purpose: Down counter for lockout, hiccup and power-good delays
// Assumes: start is a one-cycle pulse, load is at least one
// Notes:   done is high while the count is zero; a start restarts the count
`timescale 1ns/1ns
module llpf_timer (
  // Clock and reset
  input  wire logic                     clk,
  input  wire logic                     rst_n,
  // Control
  input  wire logic                     start,
  input  wire logic [llpf_pkg::TMR_W-1:0] load,
  output logic                          done
);

  logic [llpf_pkg::TMR_W-1:0] cnt_r;

  // Load on start, else count down to zero
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      cnt_r <= '0;
    end else if (start) begin
      cnt_r <= load;
    end else if (cnt_r != '0) begin
      cnt_r <= cnt_r - 1'b1;
    end
  end

  assign done = (cnt_r == '0);

endmodule : llpf_timer

// ==== src/llpf_top.sv ====
// Purpose: Light-load mode, second-phase shedding and fault response control of a boost controller
// Assumes: Comparator decisions arrive as asynchronous levels; registers over classic Wishbone
// Notes:   Long delays are parameters so a bench can shorten them
// Functional notes
// - Supply strap: cutoff on, shedding off
// - Floating strap: cutoff and shedding both on
// - Grounded strap: continuous conduction, nothing else
// - Shed phase two below drop level
// - Ramp phase two duty down over nine cycles
// - No shedding under external synchronization
// - Re-add phase two above add level
// - Re-add phase two on peak limit
// - Block shedding for lockout after re-add
// - Cutoff turns synchronous switch off at zero
// - Cutoff forced during soft-start
// - Pulse skipping only while cutoff active
// - Response strap high hiccup, low latch
// - Hiccup: stop, wait, soft-start, repeat
// - Latch: stay off, driver supply stays on
// - Input overvoltage and average overcurrent respond
// - Peak overcurrent and output overvoltage respond
// - Loop-filter short and frequency loss respond
// - Power good only after delay in run
`timescale 1ns/1ns
module llpf_top #(
  parameter int unsigned LOCK_CYC   = llpf_pkg::LOCKOUT_CYC,
  parameter int unsigned HICCUP_CYC = llpf_pkg::HICCUP_CYC,
  parameter int unsigned POWER_GOOD_FLAG_CYC  = llpf_pkg::POWER_GOOD_FLAG_CYC
) (
  // Clock and reset
  input  wire logic                      clk,
  input  wire logic                      rst_n,
  // Wishbone slave
  input  wire logic                      wb_cyc_i,
  input  wire logic                      wb_stb_i,
  input  wire logic                      wb_we_i,
  input  wire logic [llpf_pkg::ADR_W-1:0] wb_adr_i,
  input  wire logic [3:0]                wb_sel_i,
  input  wire logic [31:0]               wb_dat_i,
  output logic      [31:0]               wb_dat_o,
  output logic                           wb_ack_o,
  // Comparator and strap levels
  input  wire llpf_pkg::llpf_in_t        cmp_in,
  // Power stage controls
  output logic                           switch_en,
  output logic                           phase1_en,
  output logic                           phase2_en,
  output logic      [3:0]                ph2_duty_scale,
  output logic                           sr_cutoff_en,
  output logic      [1:0]                sr_off,
  output logic      [1:0]                pulse_skip,
  output logic                           ldo_en,
  output logic                           power_good_flag
);

  llpf_pkg::llpf_in_t    in_s;
  llpf_pkg::llpf_mode_t  mode_r;
  llpf_pkg::llpf_state_t state_r, state_nxt;
  llpf_pkg::llpf_phase_t ph_r, ph_nxt;
  llpf_pkg::llpf_fault_t fault_sticky_r;
  llpf_pkg::llpf_status_t status;
  logic [1:0] strap_cnt_r;
  logic       strap_ok_r;
  logic       ctrl_en_r;
  logic       sw_cycle_d_r;
  logic       sw_tick;
  logic       run_req;
  logic       fault_any;
  logic       de_active;
  logic       shed_mode;
  logic       shed_ok;
  logic       add_req;
  logic       lock_done;
  logic       hic_done;
  logic       pg_done;
  logic       lock_start;
  logic       hic_start;
  logic       pg_start;
  logic       wb_req;
  logic       switch_en_r;
  logic [3:0] ph2_scale_r;
  logic       sr_cutoff_en_r;
  logic [1:0] sr_off_r;
  logic [1:0] pulse_skip_r;
  logic       ldo_en_r;
  logic       power_good_r;
  logic       ack_r;
  logic [31:0] rdata_r;

  llpf_sync #(.W(llpf_pkg::IN_W)) u_sync (
    .clk   (clk),
    .rst_n (rst_n),
    .d     (cmp_in),
    .q     (in_s)
  );

  // Mode decode of the three-level strap
  function automatic llpf_pkg::llpf_mode_t decode_mode(input logic hi, input logic lo);
    if (hi && !lo) begin
      decode_mode = llpf_pkg::MODE_DE;
    end else if (!hi && !lo) begin
      decode_mode = llpf_pkg::MODE_DE_SHED;
    end else begin
      decode_mode = llpf_pkg::MODE_CCM;
    end
  endfunction : decode_mode

  // Strap capture once the synchroniser has settled after release
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      strap_cnt_r <= 2'h0;
      strap_ok_r  <= 1'b0;
      mode_r      <= llpf_pkg::MODE_CCM;
    end else if (!strap_ok_r) begin
      if (strap_cnt_r == llpf_pkg::STRAP_WAIT) begin
        strap_ok_r <= 1'b1;
        mode_r     <= decode_mode(in_s.strap_hi, in_s.strap_lo);
      end else begin
        strap_cnt_r <= strap_cnt_r + llpf_pkg::STRAP_STEP;
      end
    end
  end

  // Switching-cycle edge from the synchronised oscillator level
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      sw_cycle_d_r <= 1'b0;
    end else begin
      sw_cycle_d_r <= in_s.sw_cycle;
    end
  end

  assign sw_tick   = in_s.sw_cycle && !sw_cycle_d_r;
  assign run_req   = ctrl_en_r && in_s.en_pin && strap_ok_r;
  assign fault_any = |in_s.fault;
  assign de_active = (mode_r != llpf_pkg::MODE_CCM) || (state_r == llpf_pkg::ST_SOFT);
  assign shed_mode = (mode_r == llpf_pkg::MODE_DE_SHED);
  assign shed_ok   = shed_mode && !in_s.ext_sync && (state_r == llpf_pkg::ST_RUN);
  assign add_req   = in_s.averaged_input_current_level_above_add || (|in_s.peak_limit) || !shed_ok;

  // Fault and restart sequencing
  always_comb begin
    state_nxt = state_r;
    case (state_r)
      llpf_pkg::ST_OFF: begin
        if (run_req) begin
          state_nxt = llpf_pkg::ST_SOFT;
        end
      end
      llpf_pkg::ST_SOFT, llpf_pkg::ST_RUN: begin
        if (!run_req) begin
          state_nxt = llpf_pkg::ST_OFF;
        end else if (fault_any) begin
          state_nxt = in_s.resp_strap ? llpf_pkg::ST_HICCUP : llpf_pkg::ST_LATCH;
        end else if (state_r == llpf_pkg::ST_SOFT && in_s.ss_done) begin
          state_nxt = llpf_pkg::ST_RUN;
        end
      end
      llpf_pkg::ST_HICCUP: begin
        if (!run_req) begin
          state_nxt = llpf_pkg::ST_OFF;
        end else if (hic_done) begin
          state_nxt = llpf_pkg::ST_SOFT;
        end
      end
      llpf_pkg::ST_LATCH: begin
        if (!run_req) begin
          state_nxt = llpf_pkg::ST_OFF;
        end
      end
      default: begin
        state_nxt = llpf_pkg::ST_OFF;
      end
    endcase
  end

  // Fault state register
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      state_r <= llpf_pkg::ST_OFF;
    end else begin
      state_r <= state_nxt;
    end
  end

  assign hic_start = (state_nxt == llpf_pkg::ST_HICCUP) && (state_r != llpf_pkg::ST_HICCUP);
  assign pg_start  = (state_nxt == llpf_pkg::ST_RUN) && (state_r != llpf_pkg::ST_RUN);

  // Hiccup off-time
  llpf_timer u_hic_tmr (
    .clk   (clk),
    .rst_n (rst_n),
    .start (hic_start),
    .load  (llpf_pkg::TMR_W'(HICCUP_CYC)),
    .done  (hic_done)
  );

  // Power-good release delay
  llpf_timer u_pg_tmr (
    .clk   (clk),
    .rst_n (rst_n),
    .start (pg_start),
    .load  (llpf_pkg::TMR_W'(POWER_GOOD_FLAG_CYC)),
    .done  (pg_done)
  );

  // Phase two shedding and adding
  always_comb begin
    ph_nxt = ph_r;
    case (ph_r)
      llpf_pkg::PH_BOTH: begin
        if (!add_req && in_s.averaged_input_current_level_below_drop && lock_done) begin
          ph_nxt = llpf_pkg::PH_RAMP;
        end
      end
      llpf_pkg::PH_RAMP, llpf_pkg::PH_SINGLE: begin
        if (add_req) begin
          ph_nxt = llpf_pkg::PH_BOTH;
        end else if (ph_r == llpf_pkg::PH_RAMP && ph2_scale_r == llpf_pkg::RAMP_ZERO) begin
          ph_nxt = llpf_pkg::PH_SINGLE;
        end
      end
      default: begin
        ph_nxt = llpf_pkg::PH_BOTH;
      end
    endcase
  end

  // Phase state register
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      ph_r <= llpf_pkg::PH_BOTH;
    end else begin
      ph_r <= ph_nxt;
    end
  end

  assign lock_start = (ph_nxt == llpf_pkg::PH_BOTH) && (ph_r != llpf_pkg::PH_BOTH);

  llpf_timer u_lock_tmr (
    .clk   (clk),
    .rst_n (rst_n),
    .start (lock_start),
    .load  (llpf_pkg::TMR_W'(LOCK_CYC)),
    .done  (lock_done)
  );

  // duty scale ramps per switching cycle
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      ph2_scale_r <= llpf_pkg::RAMP_STEPS;
    end else if (ph_nxt == llpf_pkg::PH_BOTH) begin
      ph2_scale_r <= llpf_pkg::RAMP_STEPS;
    end else if (sw_tick && ph2_scale_r != llpf_pkg::RAMP_ZERO) begin
      ph2_scale_r <= ph2_scale_r - llpf_pkg::RAMP_ONE;
    end
  end

  // Switching enable follows the fault state; regulator stays on in every state after reset
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      switch_en_r <= 1'b0;
      ldo_en_r    <= 1'b0;
    end else begin
      switch_en_r <= (state_nxt == llpf_pkg::ST_SOFT) || (state_nxt == llpf_pkg::ST_RUN);
      ldo_en_r    <= 1'b1;
    end
  end

  // Cycle-by-cycle synchronous switch control and pulse skipping
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      sr_cutoff_en_r <= 1'b0;
      sr_off_r       <= 2'b00;
      pulse_skip_r   <= 2'b00;
    end else begin
      sr_cutoff_en_r <= de_active;
      sr_off_r       <= de_active ? in_s.zero_cross : 2'b00;
      pulse_skip_r   <= de_active ? in_s.skip_req : 2'b00;
    end
  end

  // power good after delay in run
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      power_good_r <= 1'b0;
    end else begin
      power_good_r <= (state_r == llpf_pkg::ST_RUN) && !pg_start && pg_done && !fault_any;
    end
  end

  assign switch_en       = switch_en_r;
  assign phase1_en       = switch_en_r;
  assign phase2_en       = switch_en_r && (ph_r != llpf_pkg::PH_SINGLE);
  assign ph2_duty_scale  = ph2_scale_r;
  assign sr_cutoff_en    = sr_cutoff_en_r;
  assign sr_off          = sr_off_r;
  assign pulse_skip      = pulse_skip_r;
  assign ldo_en          = ldo_en_r;
  assign power_good_flag = power_good_r;

  // Wishbone request, one acknowledge per access
  assign wb_req = wb_cyc_i && wb_stb_i && !ack_r;

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      ack_r <= 1'b0;
    end else begin
      ack_r <= wb_req;
    end
  end

  // Control register write
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      ctrl_en_r <= llpf_pkg::CTRL_EN_RST;
    end else if (wb_req && wb_we_i && wb_sel_i[0] && wb_adr_i == llpf_pkg::ADR_CTRL) begin
      ctrl_en_r <= wb_dat_i[llpf_pkg::CTRL_EN_BIT];
    end
  end

  // Sticky fault causes, write one to clear, set wins
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      fault_sticky_r <= llpf_pkg::FAULT_NONE;
    end else if (wb_req && wb_we_i && wb_sel_i[0] && wb_adr_i == llpf_pkg::ADR_FAULT) begin
      fault_sticky_r <= (fault_sticky_r & ~wb_dat_i[$bits(llpf_pkg::llpf_fault_t)-1:0])
                        | in_s.fault;
    end else begin
      fault_sticky_r <= fault_sticky_r | in_s.fault;
    end
  end

  // Status word
  always_comb begin
    status.mode       = mode_r;
    status.de_active  = de_active;
    status.shed_en    = shed_ok;
    status.ph2_on     = (ph_r != llpf_pkg::PH_SINGLE);
    status.state      = state_r;
    status.phase      = ph_r;
    status.power_good = power_good_r;
    status.hiccup_sel = in_s.resp_strap;
  end

  // Read data, zero for unmapped offsets
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      rdata_r <= llpf_pkg::DATA_ZERO;
    end else if (wb_req) begin
      case (wb_adr_i)
        llpf_pkg::ADR_CTRL:   rdata_r <= {{31{1'b0}}, ctrl_en_r};
        llpf_pkg::ADR_STATUS: rdata_r <= {{llpf_pkg::STAT_PAD{1'b0}}, status};
        llpf_pkg::ADR_FAULT:  rdata_r <= {{llpf_pkg::FAULT_PAD{1'b0}}, fault_sticky_r};
        default:              rdata_r <= llpf_pkg::DATA_ZERO;
      endcase
    end
  end

  assign wb_dat_o = rdata_r;
  assign wb_ack_o = ack_r;

  // Checks on the power-stage control
  default clocking cb @(posedge clk); endclocking
  default disable iff (!rst_n);

  a_ccm_no_cutoff: assert property (
    (mode_r == llpf_pkg::MODE_CCM && state_r == llpf_pkg::ST_RUN) |=> !sr_cutoff_en_r)
    else $error("cutoff active in continuous mode");
  a_de_mode_cutoff: assert property (
    (mode_r != llpf_pkg::MODE_CCM && strap_ok_r) |=> sr_cutoff_en_r)
    else $error("cutoff missing in emulation mode");
  a_soft_forces_de: assert property (
    (state_r == llpf_pkg::ST_SOFT) |=> sr_cutoff_en_r)
    else $error("cutoff missing in soft-start");
  a_no_shed_dem: assert property (
    (mode_r != llpf_pkg::MODE_DE_SHED && ph_r == llpf_pkg::PH_BOTH) |=> ph_r == llpf_pkg::PH_BOTH)
    else $error("phase shed without shedding mode");
  a_no_shed_sync: assert property (
    (in_s.ext_sync && ph_r == llpf_pkg::PH_BOTH) |=> ph_r == llpf_pkg::PH_BOTH)
    else $error("phase shed under external sync");
  a_drop_averaged_input_current_level: assert property (
    (ph_r == llpf_pkg::PH_BOTH && shed_ok && in_s.averaged_input_current_level_below_drop && !in_s.averaged_input_current_level_above_add
     && in_s.peak_limit == 2'b00 && lock_done) |=> ph_r == llpf_pkg::PH_RAMP)
    else $error("no drop below threshold");
  a_add_on_limit: assert property (
    (ph_r != llpf_pkg::PH_BOTH && in_s.peak_limit != 2'b00) |=> ph_r == llpf_pkg::PH_BOTH)
    else $error("no re-add on peak limit");
  a_add_on_averaged_input_current_level: assert property (
    (ph_r != llpf_pkg::PH_BOTH && in_s.averaged_input_current_level_above_add) |=> ph_r == llpf_pkg::PH_BOTH)
    else $error("no re-add above threshold");
  a_ramp_start_full: assert property (
    (ph_r == llpf_pkg::PH_BOTH ##1 ph_r == llpf_pkg::PH_RAMP)
    |-> ph2_scale_r == llpf_pkg::RAMP_STEPS && switch_en_r)
    else $error("ramp not starting from full duty");
  a_ramp_no_rise: assert property (
    (ph_r == llpf_pkg::PH_RAMP ##1 ph_r == llpf_pkg::PH_RAMP) |-> ph2_scale_r <= $past(ph2_scale_r))
    else $error("ramp duty rose");
  a_lockout_hold: assert property (
    (ph_r != llpf_pkg::PH_BOTH ##1 ph_r == llpf_pkg::PH_BOTH) |-> !lock_done)
    else $error("lockout not running after re-add");
  a_fault_stop: assert property (
    (fault_any && run_req && (state_r == llpf_pkg::ST_RUN || state_r == llpf_pkg::ST_SOFT))
    |=> !switch_en_r && state_r == (in_s.resp_strap ? llpf_pkg::ST_HICCUP : llpf_pkg::ST_LATCH))
    else $error("fault did not stop switching");
  a_latch_hold: assert property (
    (state_r == llpf_pkg::ST_LATCH && run_req) |=> state_r == llpf_pkg::ST_LATCH && ldo_en_r)
    else $error("latch released while enabled");
  a_hiccup_sel: assert property (
    (state_r == llpf_pkg::ST_RUN && run_req && fault_any && in_s.resp_strap)
    |=> state_r == llpf_pkg::ST_HICCUP)
    else $error("hiccup not chosen");
  a_power_good_flag_delay: assert property (
    $rose(state_r == llpf_pkg::ST_RUN) |-> (!power_good_r) [*8])
    else $error("power good without delay");
  a_skip_gated: assert property (
    !$past(de_active) |-> pulse_skip_r == 2'b00 && sr_off_r == 2'b00)
    else $error("skip or cutoff outside emulation");

  c_hiccup_restart: cover property (state_r == llpf_pkg::ST_HICCUP ##1 state_r == llpf_pkg::ST_SOFT);
  c_latch_entry: cover property (state_r == llpf_pkg::ST_RUN ##1 state_r == llpf_pkg::ST_LATCH);
  c_phase_single: cover property (ph_r == llpf_pkg::PH_RAMP ##1 ph_r == llpf_pkg::PH_SINGLE);
  c_phase_readd: cover property (ph_r == llpf_pkg::PH_SINGLE ##1 ph_r == llpf_pkg::PH_BOTH);

endmodule : llpf_top
